// File: temp_readout_regs.vh
// constants for the thermometer conversion and readout block
`ifndef TEMP_READOUT_REGS_VH
`define TEMP_READOUT_REGS_VH

// serial command codes, one byte each
`define CMD_BEGIN_CONV 8'h5a
`define CMD_HALT_CONV 8'h3c
`define CMD_FETCH_RESULT 8'ha5
`define CMD_WRITE_CONFIG 8'h0f
`define CMD_READ_CONFIG 8'hc3

// configuration byte field positions
`define CFG_SINGLE_BIT 0
`define CFG_HOST_CTRL_BIT 1
`define CFG_RES_LO_BIT 2
`define CFG_RES_HI_BIT 3
`define CFG_NV_BUSY_BIT 4
`define CFG_DONE_BIT 7

// reset values
`define RESULT_RESET 12'hc40
`define CONFIG_NV_RESET 4'hf
// pins at rest {frame, link clock, data}: frame low, clock and data pulled high
`define PINS_IDLE 3'h3

// timing, in microseconds, and the clock rate
`define CLK_MHZ 125
`define CONV_TIME_12B_US 750000
`define NV_WRITE_TYP_US 4000
`define SA_ONESHOT_US 10000

// serial word lengths
`define CMD_BITS 4'd8
`define RESULT_BITS 4'd12
`define CONFIG_BITS 4'd8

`endif

// File: pin_sync.v
// two-stage synchroniser for pins coming from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // pins in, synchronised levels out
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_sync_out
);
  reg [WIDTH-1:0] stage1_r;

  // first stage feeds only the second; reset to rest levels so no false edge follows
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1_r <= IDLE;
      pin_sync_out <= IDLE;
    end else begin
      stage1_r <= pin_in;
      pin_sync_out <= stage1_r;
    end
  end
endmodule // pin_sync
`default_nettype wire

// File: nv_config_store.v
// non-volatile configuration cell with a timed write cycle
`timescale 1ns/10ps
`default_nettype none
`include "temp_readout_regs.vh"
module nv_config_store #(
  parameter WR_CYCLES = `NV_WRITE_TYP_US * `CLK_MHZ,
  parameter CNT_W = 20
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // write request
  input wire wr_req,
  input wire [3:0] wr_data,
  // stored value and status
  output reg [3:0] cfg_r,
  output reg busy_r
);
  reg [3:0] pend_r;
  reg [CNT_W-1:0] cnt_r;

  // reset stands in for the stored value surviving power loss
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_r <= `CONFIG_NV_RESET;
      pend_r <= 4'h0;
      busy_r <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
    end else if (busy_r) begin
      // commit only when the write cycle ends
      if (cnt_r == WR_CYCLES[CNT_W-1:0] - 1'b1) begin
        cfg_r <= pend_r;
        busy_r <= 1'b0;
      end
      cnt_r <= cnt_r + 1'b1;
    end else if (wr_req) begin
      // writes arriving while busy are dropped
      pend_r <= wr_data;
      busy_r <= 1'b1;
      cnt_r <= {CNT_W{1'b0}};
    end
  end
endmodule // nv_config_store
`default_nettype wire

// File: temperature_conversion_readout.v
// conversion control, result register and 3-wire serial slave
`timescale 1ns/10ps
`default_nettype none
`include "temp_readout_regs.vh"
module temperature_conversion_readout #(
  parameter CONV_12B_CYCLES = `CONV_TIME_12B_US * `CLK_MHZ,
  parameter NV_WR_CYCLES = `NV_WRITE_TYP_US * `CLK_MHZ,
  parameter SA_ONESHOT_CYCLES = `SA_ONESHOT_US * `CLK_MHZ,
  parameter CNT_W = 27
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // 3-wire serial link pins
  input wire frame_select,
  input wire clock_or_convert_pin,
  input wire dq_in,
  output wire dq_out,
  output wire dq_oe_n,
  // sensor front end, same clock domain
  input wire [11:0] temp_sample,
  // status
  output reg conv_busy_r,
  output reg [11:0] temperature_result
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  localparam PH_CMD = 2'd0;
  localparam PH_WDATA = 2'd1;
  localparam PH_TX = 2'd2;
  localparam PH_DONE = 2'd3;

  // bits below the selected resolution forced to zero
  function [11:0] res_mask;
    input [1:0] res;
    begin
      case (res)
        2'd0: res_mask = 12'hff8;
        2'd1: res_mask = 12'hffc;
        2'd2: res_mask = 12'hffe;
        default: res_mask = 12'hfff;
      endcase
    end
  endfunction

  // conversion length, halving per bit dropped from twelve
  function [CNT_W-1:0] conv_len;
    input [1:0] res;
    reg [CNT_W-1:0] full;
    begin
      full = CONV_12B_CYCLES[CNT_W-1:0];
      conv_len = full >> (2'd3 - res);
    end
  endfunction

  // synchronised pins
  wire [2:0] pins_s;
  wire frame_s;
  wire link_clk_s;
  wire dq_s;
  reg link_clk_d_r;
  wire clk_rise;
  wire clk_fall;

  pin_sync #(
    .WIDTH(3),
    .IDLE(`PINS_IDLE)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({frame_select, clock_or_convert_pin, dq_in}),
    .pin_sync_out(pins_s)
  );

  assign frame_s = pins_s[2];
  assign link_clk_s = pins_s[1];
  assign dq_s = pins_s[0];
  assign clk_rise = link_clk_s & ~link_clk_d_r;
  assign clk_fall = ~link_clk_s & link_clk_d_r;

  // non-volatile configuration
  reg cfg_wr_req;
  reg [3:0] cfg_wr_data;
  wire [3:0] cfg_nv;
  wire nv_busy;
  wire [1:0] res_sel;
  wire single_conversion_select;
  wire host_ctrl;

  nv_config_store #(
    .WR_CYCLES(NV_WR_CYCLES),
    .CNT_W(CNT_W)
  ) u_nv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_req(cfg_wr_req),
    .wr_data(cfg_wr_data),
    .cfg_r(cfg_nv),
    .busy_r(nv_busy)
  );

  assign res_sel = {cfg_nv[`CFG_RES_HI_BIT], cfg_nv[`CFG_RES_LO_BIT]};
  assign single_conversion_select = cfg_nv[`CFG_SINGLE_BIT];
  assign host_ctrl = cfg_nv[`CFG_HOST_CTRL_BIT];

  // serial slave state
  reg [1:0] phase_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] rx_r;
  reg [11:0] tx_r;
  reg [3:0] tx_left_r;
  reg drive_r;
  reg cmd_begin;
  reg cmd_halt;
  reg done_flag_r;
  wire [7:0] rx_byte;
  wire [7:0] config_byte;

  assign rx_byte = {dq_s, rx_r[7:1]};
  assign config_byte = {done_flag_r, 2'b00, nv_busy, cfg_nv};
  // data is a flop; enable low while this end drives
  assign dq_out = tx_r[0];
  assign dq_oe_n = ~drive_r;

  // edge history for the link clock; resets high like the idle pin
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      link_clk_d_r <= 1'b1;
    end else begin
      link_clk_d_r <= link_clk_s;
    end
  end

  // receive on rising link clock, transmit on falling
  always @(posedge sys_clk) begin
    cmd_begin <= 1'b0;
    cmd_halt <= 1'b0;
    cfg_wr_req <= 1'b0;
    if (!rst_n) begin
      phase_r <= PH_CMD;
      bit_cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 12'h000;
      tx_left_r <= 4'h0;
      drive_r <= 1'b0;
      cfg_wr_data <= 4'h0;
    end else if (!frame_s) begin
      // frame end drops any half-received word
      phase_r <= PH_CMD;
      bit_cnt_r <= 4'h0;
      drive_r <= 1'b0;
    end else begin
      case (phase_r)
        PH_CMD: begin
          if (clk_rise) begin
            rx_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == `CMD_BITS - 1'b1) begin
              bit_cnt_r <= 4'h0;
              phase_r <= PH_DONE;
              case (rx_byte)
                `CMD_BEGIN_CONV: cmd_begin <= 1'b1;
                `CMD_HALT_CONV: cmd_halt <= 1'b1;
                `CMD_FETCH_RESULT: begin
                  tx_r <= temperature_result;
                  tx_left_r <= `RESULT_BITS;
                  phase_r <= PH_TX;
                end
                `CMD_READ_CONFIG: begin
                  tx_r <= {4'h0, config_byte};
                  tx_left_r <= `CONFIG_BITS;
                  phase_r <= PH_TX;
                end
                `CMD_WRITE_CONFIG: phase_r <= PH_WDATA;
                default: phase_r <= PH_DONE;
              endcase
            end
          end
        end
        PH_WDATA: begin
          if (clk_rise) begin
            rx_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            // only a complete byte reaches storage
            if (bit_cnt_r == `CONFIG_BITS - 1'b1) begin
              cfg_wr_req <= 1'b1;
              cfg_wr_data <= rx_byte[3:0];
              phase_r <= PH_DONE;
            end
          end
        end
        PH_TX: begin
          if (clk_fall) begin
            if (!drive_r) begin
              drive_r <= 1'b1;
            end else if (tx_left_r == 4'h1) begin
              drive_r <= 1'b0;
              tx_left_r <= 4'h0;
              phase_r <= PH_DONE;
            end else begin
              tx_r <= {1'b0, tx_r[11:1]};
              tx_left_r <= tx_left_r - 1'b1;
            end
          end
        end
        default: begin
          // extra clocks in a finished frame are ignored
          drive_r <= 1'b0;
        end
      endcase
    end
  end

  // conversion requests from the host side and from the stand-alone convert pin
  reg host_cont_r;
  reg host_once_r;
  reg sa_once_r;
  reg [CNT_W-1:0] sa_low_cnt_r;
  wire standalone;
  wire sa_cont;
  wire want_conv;
  wire entering;

  assign standalone = ~host_ctrl & ~frame_s;
  // low convert pin keeps conversions running, select bit unused
  assign sa_cont = standalone & ~link_clk_s;
  assign want_conv = host_cont_r | host_once_r | sa_cont | sa_once_r;

  reg state_r;
  reg [CNT_W-1:0] conv_cnt_r;
  wire conv_end;

  assign conv_end = (state_r == ST_CONV) && (conv_cnt_r == conv_len(res_sel) - 1'b1);
  assign entering = want_conv && ((state_r == ST_IDLE) || conv_end);

  // begin and halt, mode taken from the select bit
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      host_cont_r <= 1'b0;
      host_once_r <= 1'b0;
    end else begin
      if (cmd_halt) begin
        host_cont_r <= 1'b0;
      end
      if (entering) begin
        host_once_r <= 1'b0;
      end
      if (cmd_begin && !single_conversion_select) begin
        host_cont_r <= 1'b1;
      end
      if (cmd_begin && single_conversion_select) begin
        host_once_r <= 1'b1;
      end
    end
  end

  // stand-alone: a short low pulse asks for exactly one conversion
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sa_low_cnt_r <= {CNT_W{1'b0}};
      sa_once_r <= 1'b0;
    end else begin
      if (!standalone || link_clk_s) begin
        sa_low_cnt_r <= {CNT_W{1'b0}};
      end else if (sa_low_cnt_r != SA_ONESHOT_CYCLES[CNT_W-1:0]) begin
        sa_low_cnt_r <= sa_low_cnt_r + 1'b1;
      end
      if (entering || frame_s) begin
        sa_once_r <= 1'b0;
      end
      // set after clear so a coincident request is kept
      // the low level has already started a conversion; a second request would double it
      if (standalone && clk_rise && state_r == ST_IDLE && sa_low_cnt_r != SA_ONESHOT_CYCLES[CNT_W-1:0]) begin
        sa_once_r <= 1'b1;
      end
    end
  end

  // conversion sequencer; result replaced whole at the end
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      conv_cnt_r <= {CNT_W{1'b0}};
      conv_busy_r <= 1'b0;
      temperature_result <= `RESULT_RESET;
    end else begin
      case (state_r)
        ST_IDLE: begin
          conv_cnt_r <= {CNT_W{1'b0}};
          if (want_conv) begin
            state_r <= ST_CONV;
            conv_busy_r <= 1'b1;
          end
        end
        ST_CONV: begin
          conv_cnt_r <= conv_cnt_r + 1'b1;
          if (conv_end) begin
            // two's complement, sign in bit 11, low bits cleared
            temperature_result <= temp_sample & res_mask(res_sel);
            conv_cnt_r <= {CNT_W{1'b0}};
            if (!want_conv) begin
              state_r <= ST_IDLE;
              conv_busy_r <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
          conv_busy_r <= 1'b0;
        end
      endcase
    end
  end

  // done flag: cleared by begin, a finishing conversion wins
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      done_flag_r <= 1'b0;
    end else if (conv_end) begin
      done_flag_r <= 1'b1;
    end else if (cmd_begin) begin
      done_flag_r <= 1'b0;
    end
  end
endmodule // temperature_conversion_readout
`default_nettype wire

// File: readout_checker.sv
// port assertions for the thermometer readout block
`timescale 1ns/10ps
`default_nettype none
module readout_checker #(
  parameter int CONV_12B_CYCLES = 800
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial link pins
  input wire logic frame_select,
  input wire logic clock_or_convert_pin,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe_n,
  // sensor and status
  input wire logic [11:0] temp_sample,
  input wire logic conv_busy_r,
  input wire logic [11:0] temperature_result
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] busy_cnt_r;
  // busy run length, restarted when the result value changes so back to back runs with different results stay apart
  always @(posedge sys_clk) begin
    if (!rst_n || !conv_busy_r || $changed(temperature_result)) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 32'h1;
    end
  end
  sequence busy_start;
    $rose(conv_busy_r);
  endsequence
  sequence old_held;
    $stable(temperature_result) [*8];
  endsequence
  a_reset_result: assert property (disable iff (1'b0) !rst_n |=> temperature_result == 12'hc40)
    else $error("result not at reset value");
  a_result_at_end: assert property ($changed(temperature_result) |-> $past(conv_busy_r))
    else $error("result changed with no conversion");
  a_sign_at_end: assert property ($changed(temperature_result) && $stable(temp_sample)
    |-> temperature_result[11:3] == temp_sample[11:3])
    else $error("result top bits differ from sample");
  a_hold_old: assert property (busy_start |=> old_held)
    else $error("result moved early in conversion");
  a_conv_bound: assert property (conv_busy_r |-> busy_cnt_r <= CONV_12B_CYCLES)
    else $error("conversion too long");
  a_release_idle: assert property (!frame_select [*6] |-> dq_oe_n)
    else $error("data driven outside a frame");
  a_drive_in_frame: assert property ($fell(dq_oe_n) |-> frame_select)
    else $error("drive began without frame");
  a_bit_stands: assert property ($fell(dq_oe_n) |=> !dq_oe_n [*6])
    else $error("first bit too short");
endmodule // readout_checker
bind temperature_conversion_readout readout_checker #(.CONV_12B_CYCLES(CONV_12B_CYCLES)) readout_checker_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .frame_select(frame_select), .clock_or_convert_pin(clock_or_convert_pin),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .temp_sample(temp_sample), .conv_busy_r(conv_busy_r),
  .temperature_result(temperature_result));
`default_nettype wire

// File: link_host.sv
// host model for the 3-wire link
`timescale 1ns/10ps
`default_nettype none
module link_host (
  // clock
  input wire logic sys_clk,
  // pins driven by the host
  output logic frame_select,
  output logic link_clk,
  output logic dq_drive,
  output logic dq_en,
  // resolved data wire
  input wire logic dq_wire
);
  // clock idles high so stand-alone logic never sees a convert request
  initial begin
    frame_select = 1'b0;
    link_clk = 1'b1;
    dq_drive = 1'b1;
    dq_en = 1'b0;
  end
  // half link period, 32 ns
  task automatic half;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // one frame: command and nwr write bits out, nrd bits in
  task automatic xfer(input logic [15:0] tx, input int nwr, input int nrd, output logic [11:0] rd);
    rd = 12'h0;
    frame_select = 1'b1;
    half;
    for (int i = 0; i < 8 + nwr; i++) begin
      link_clk = 1'b0;
      dq_en = 1'b1;
      dq_drive = tx[i];
      half;
      link_clk = 1'b1;
      half;
    end
    dq_en = 1'b0;
    for (int i = 0; i < nrd; i++) begin
      link_clk = 1'b0;
      half;
      link_clk = 1'b1;
      rd[i] = dq_wire;
      half;
    end
    // trailing fall lets the device release the wire
    link_clk = 1'b0;
    half;
    link_clk = 1'b1;
    half;
    frame_select = 1'b0;
    half;
  endtask
  // convert pin level in stand-alone use
  task automatic pin(input logic lvl);
    link_clk = lvl;
  endtask
endmodule // link_host
`default_nettype wire

// File: tb.sv
// self-checking bench for the thermometer readout block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int CONV = 800;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] temp_sample = 12'h000;
  logic [11:0] rd;
  logic [11:0] tbl [4] = '{12'hf5f, 12'h197, 12'he6f, 12'h0a3};
  int n_fail = 0;
  int total_checks = 0;
  int cyc;
  wire logic frame_select, link_clk, dq_drive, dq_en, dq_wire, dq_out, dq_oe_n, conv_busy_r;
  wire logic [11:0] temperature_result;
  // data wire has a pull-up when nobody drives
  assign dq_wire = !dq_oe_n ? dq_out : (dq_en ? dq_drive : 1'b1);
  always #4 sys_clk = ~sys_clk;
  temperature_conversion_readout #(.CONV_12B_CYCLES(CONV), .NV_WR_CYCLES(50), .SA_ONESHOT_CYCLES(100),
    .CNT_W(27)) temperature_conversion_readout_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .frame_select(frame_select), .clock_or_convert_pin(link_clk), .dq_in(dq_wire), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .temp_sample(temp_sample), .conv_busy_r(conv_busy_r),
    .temperature_result(temperature_result));
  link_host link_host_inst (.sys_clk(sys_clk), .frame_select(frame_select), .link_clk(link_clk),
    .dq_drive(dq_drive), .dq_en(dq_en), .dq_wire(dq_wire));
  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait on busy (sel high) or on the result
  task automatic wait_for(input logic sel, input logic [11:0] exp, input int bound);
    cyc = 0;
    while ((sel ? {11'h0, conv_busy_r} : temperature_result) !== exp) begin
      @(posedge sys_clk);
      #1;
      cyc++;
      if (cyc > bound) begin
        check("wait", exp, sel ? {11'h0, conv_busy_r} : temperature_result);
        complete_run;
      end
    end
  endtask
  // config write, nv idle gap, read back
  task automatic cfg(input logic [3:0] v);
    link_host_inst.xfer({4'h0, v, 8'h0f}, 8, 0, rd);
    repeat (100) @(posedge sys_clk);
    #1;
    link_host_inst.xfer(16'h00c3, 0, 8, rd);
    check("config", {8'h0, v}, {7'h0, rd[4:0]});
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check("reset result", 12'hc40, temperature_result);
    link_host_inst.xfer(16'h00a5, 0, 12, rd);
    check("fetch", 12'hc40, rd);
    // single shot at each resolution, low bits masked
    for (int r = 0; r < 4; r++) begin
      cfg({r[1:0], 2'b11});
      temp_sample = tbl[r];
      link_host_inst.xfer(16'h005a, 0, 0, rd);
      wait_for(1'b1, 12'h0, CONV);
      check("conv time", 12'h1, {11'h0, cyc <= (CONV >> (3 - r)) && cyc > (CONV >> (4 - r))});
      check("result", tbl[r] & (12'hfff << (3 - r)), temperature_result);
      link_host_inst.xfer(16'h00a5, 0, 12, rd);
      check("fetch", tbl[r] & (12'hfff << (3 - r)), rd);
      repeat (100) @(posedge sys_clk);
      #1;
      check("single idle", 12'h0, {11'h0, conv_busy_r});
    end
    // continuous at nine bits until halted
    cfg(4'b0010);
    temp_sample = 12'h008;
    link_host_inst.xfer(16'h005a, 0, 0, rd);
    wait_for(1'b0, 12'h008, 120);
    temp_sample = 12'hff8;
    wait_for(1'b0, 12'hff8, 120);
    link_host_inst.xfer(16'h003c, 0, 0, rd);
    wait_for(1'b1, 12'h0, 120);
    temp_sample = 12'h190;
    repeat (300) @(posedge sys_clk);
    #1;
    check("halted", 12'hff8, temperature_result);
    // stand-alone: long low pin runs on although single is set
    cfg(4'b0001);
    temp_sample = 12'h020;
    link_host_inst.pin(1'b0);
    wait_for(1'b0, 12'h020, 150);
    temp_sample = 12'h040;
    wait_for(1'b0, 12'h040, 150);
    link_host_inst.pin(1'b1);
    wait_for(1'b1, 12'h0, 150);
    // short low pulse: exactly one conversion, select bit still ignored
    temp_sample = 12'h060;
    link_host_inst.pin(1'b0);
    repeat (40) @(posedge sys_clk);
    #1;
    link_host_inst.pin(1'b1);
    wait_for(1'b0, 12'h060, 150);
    temp_sample = 12'h080;
    repeat (150) @(posedge sys_clk);
    #1;
    check("one shot result", 12'h060, temperature_result);
    check("one shot idle", 12'h0, {11'h0, conv_busy_r});
    complete_run;
  end
endmodule // tb
`default_nettype wire
